/* File: hdl/vlsu_pkg.sv */
// package: constants and carriers for the vector load/store unit
`default_nettype none
package vlsu_pkg;
    localparam int ADDR_W     = 24;
    localparam int DATA_W     = 64;
    localparam int VLEN_W     = 7;
    localparam int VREG_W     = 3;
    localparam int AREG_W     = 3;
    localparam int CNT_W      = 8;
    localparam int NUM_PORTS  = 3;
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;
    localparam logic [AREG_W-1:0] UNIT_STRIDE_K = 3'h0;
    localparam logic [ADDR_W-1:0] UNIT_STRIDE   = 24'h000001;
    // timing offsets added to the vector length, in clock periods
    localparam logic [CNT_W-1:0] SLOAD_DEST_OFS  = 8'h11;
    localparam logic [CNT_W-1:0] SLOAD_PORT_OFS  = 8'h06;
    localparam logic [CNT_W-1:0] SSTORE_SRC_OFS  = 8'h03;
    localparam logic [CNT_W-1:0] SSTORE_PORT_OFS = 8'h07;
    localparam logic [CNT_W-1:0] GLOAD_DEST_OFS  = 8'h15;
    localparam logic [CNT_W-1:0] GIDX_OFS        = 8'h03;
    localparam logic [CNT_W-1:0] GPORT_OFS       = 8'h0A;
    localparam logic [CNT_W-1:0] CNT_ONE         = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO        = 8'h00;

    typedef enum logic [3:0] {
        VLSU_OP_SLOAD  = 4'h1,
        VLSU_OP_SSTORE = 4'h2,
        VLSU_OP_GLOAD  = 4'h4,
        VLSU_OP_SSCAT  = 4'h8
    } vlsu_op_e;

    typedef struct packed {
        vlsu_op_e            op;
        logic [VREG_W-1:0]   vreg;
        logic [VREG_W-1:0]   index_vreg;
        logic [AREG_W-1:0]   stride_k;
    } vlsu_cmd_s;

    typedef struct packed {
        logic                req;
        logic                write;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } vlsu_mreq_s;
endpackage
`default_nettype wire

/* File: hdl/vlsu_timer.sv */
// down-counter holding a busy or reserved level for a loaded number of periods
`default_nettype none
module vlsu_timer
    import vlsu_pkg::*;
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // control
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] count,
    // status
    output var  logic             busy
);
    logic [CNT_W-1:0] remain;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            remain <= CNT_ZERO;
        end else if (load) begin
            remain <= count;
        end else if (remain != CNT_ZERO) begin
            remain <= remain - CNT_ONE;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (load) begin
            busy <= (count != CNT_ZERO);
        end else begin
            busy <= (remain > CNT_ONE);
        end
    end
endmodule
`default_nettype wire

/* File: hdl/vlsu_top.sv */
// vector load/store unit: issue checks, address generation, port timers
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// How it works
// - strided load fetches length words into target vector, base plus stride steps.
// - strided store writes length words from source vector, base plus stride steps.
// - element index starts at zero, steps one; stride is signed 24-bit.
// - gather/scatter address is base plus signed low 24 bits of index element.
// - word count equals the vector length register value.
// - stride designator zero means increment of one.
// - loads take port B, else port A; stores take port C.
// - load holds while A and B busy; store holds while C busy.
// - indexed ops serialise; all hold while base register reserved.
// - strided op holds while its stride register (1..7) is reserved.
// - all hold while a scalar reference is in periods one to three.
// - hold on reserved target, source, or index vector registers.
// - without dual direction, load holds on C busy, store on A or B busy.
// - separate commands switch dual direction memory transfers off and on.
// - strided load: issue one period, dest ready at VL+17, port busy VL+6.
// - strided store: source free at VL+3, port C busy VL+7.
// - gather: dest at VL+21, index at VL+3, port and gather busy VL+10.
// - scatter: source and index free at VL+3, port and scatter busy VL+10.
// - transfer rate follows bank conflicts signalled by memory acceptance.
// - elements go strictly in order; a stalled element delays all behind.
// - chained consumers stall in the period after memory refuses a load word.
module vlsu_top
    import vlsu_pkg::*;
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // instruction issue
    input  wire logic                issue_req,
    input  wire vlsu_cmd_s           issue_cmd,
    output logic                     issue_ack,
    input  wire logic                dual_direction_off,
    input  wire logic                dual_direction_on,
    // architectural state
    input  wire logic [VLEN_W-1:0]   vector_length_reg,
    input  wire logic [ADDR_W-1:0]   base_address_reg,
    input  wire logic [ADDR_W-1:0]   stride_reg,
    input  wire logic                base_reserved,
    input  wire logic                stride_reserved,
    input  wire logic                scalar_ref_early,
    input  wire logic [7:0]          vreg_reserved_operand,
    input  wire logic [7:0]          vreg_reserved_result,
    // vector register file access
    output logic [VREG_W-1:0]        vrf_reg,
    output logic [VLEN_W-1:0]        vrf_elem,
    input  wire logic [DATA_W-1:0]   vrf_rdata,
    input  wire logic [DATA_W-1:0]   index_rdata,
    output logic                     vrf_we,
    output logic [DATA_W-1:0]        vrf_wdata,
    // memory port (selected port carries the request)
    output vlsu_mreq_s               mem_req,
    output logic [1:0]               mem_port,
    input  wire logic                mem_accept,
    input  wire logic                mem_rvalid,
    input  wire logic [DATA_W-1:0]   mem_rdata,
    // status
    output logic [NUM_PORTS-1:0]     port_busy,
    output logic                     gather_busy,
    output logic                     scatter_busy,
    output logic                     dest_pending,
    output logic                     src_pending,
    output logic                     index_pending,
    output logic                     chain_stall,
    output logic                     dual_direction
);
    typedef enum logic [2:0] {
        VLSU_IDLE = 3'b001,
        VLSU_REQ  = 3'b010,
        VLSU_DONE = 3'b100
    } vlsu_state_e;

    logic                rst_meta;
    logic                rst_n;
    vlsu_state_e         state;
    vlsu_cmd_s           cmd;
    logic [VLEN_W-1:0]   elem;
    logic [VLEN_W-1:0]   total;
    logic [VLEN_W-1:0]   rd_elem;
    logic [VLEN_W-1:0]   off_elem;
    logic                view_rd;
    logic                fetch_ok;
    logic                load_next;
    logic [ADDR_W-1:0]   cur_addr;
    logic [ADDR_W-1:0]   base;
    logic [ADDR_W-1:0]   step;
    logic                is_load;
    logic                is_idx;
    logic                hold;
    logic                go;
    logic                ports_ab_busy;
    logic                use_b;
    logic [CNT_W-1:0]    vl_ext;
    logic [NUM_PORTS-1:0] port_load;
    logic [CNT_W-1:0]    port_cnt;
    logic                dest_load;
    logic [CNT_W-1:0]    dest_cnt;
    logic                src_load;
    logic                idx_load;
    logic                gat_load;
    logic                sca_load;
    logic [NUM_PORTS-1:0] port_busy_t;
    logic                gather_t;
    logic                scatter_t;
    logic                dest_t;
    logic                src_t;
    logic                idx_t;

    //////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // issue checks
    assign is_load       = issue_cmd.op inside {VLSU_OP_SLOAD, VLSU_OP_GLOAD};
    assign is_idx        = issue_cmd.op inside {VLSU_OP_GLOAD, VLSU_OP_SSCAT};
    assign ports_ab_busy = port_busy_t[PORT_A] & port_busy_t[PORT_B];
    assign vl_ext        = CNT_W'(vector_length_reg);

    always_comb begin
        hold = base_reserved | scalar_ref_early;
        hold = hold | (state != VLSU_IDLE);
        if (is_load) begin
            hold = hold | ports_ab_busy;
            hold = hold | vreg_reserved_operand[issue_cmd.vreg];
            hold = hold | vreg_reserved_result[issue_cmd.vreg];
            hold = hold | (!dual_direction & port_busy_t[PORT_C]);
        end else begin
            hold = hold | port_busy_t[PORT_C];
            hold = hold | vreg_reserved_operand[issue_cmd.vreg];
            hold = hold | (!dual_direction & (port_busy_t[PORT_A] | port_busy_t[PORT_B]));
        end
        if (is_idx) begin
            hold = hold | gather_t | scatter_t;
            hold = hold | vreg_reserved_operand[issue_cmd.index_vreg];
        end else if (issue_cmd.stride_k != UNIT_STRIDE_K) begin
            hold = hold | stride_reserved;
        end
    end

    assign go    = issue_req & !hold;
    assign use_b = !port_busy_t[PORT_B];

    // timer loads at issue; one issue period, then lengths from the length
    always_comb begin
        port_load = '0;
        port_cnt  = CNT_ZERO;
        dest_load = 1'b0;
        dest_cnt  = CNT_ZERO;
        src_load  = 1'b0;
        idx_load  = 1'b0;
        gat_load  = 1'b0;
        sca_load  = 1'b0;
        if (go) begin
            unique case (issue_cmd.op)
                VLSU_OP_SLOAD: begin
                    port_load[use_b ? PORT_B : PORT_A] = 1'b1;
                    port_cnt  = vl_ext + SLOAD_PORT_OFS;
                    dest_load = 1'b1;
                    dest_cnt  = vl_ext + SLOAD_DEST_OFS;
                end
                VLSU_OP_SSTORE: begin
                    port_load[PORT_C] = 1'b1;
                    port_cnt  = vl_ext + SSTORE_PORT_OFS;
                    src_load  = 1'b1;
                end
                VLSU_OP_GLOAD: begin
                    port_load[use_b ? PORT_B : PORT_A] = 1'b1;
                    port_cnt  = vl_ext + GPORT_OFS;
                    dest_load = 1'b1;
                    dest_cnt  = vl_ext + GLOAD_DEST_OFS;
                    idx_load  = 1'b1;
                    gat_load  = 1'b1;
                end
                VLSU_OP_SSCAT: begin
                    port_load[PORT_C] = 1'b1;
                    port_cnt  = vl_ext + GPORT_OFS;
                    src_load  = 1'b1;
                    idx_load  = 1'b1;
                    sca_load  = 1'b1;
                end
                default: ;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // busy and reservation timers
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            vlsu_timer u_port (
                .clock (clock),
                .rst_n (rst_n),
                .load  (port_load[p]),
                .count (port_cnt),
                .busy  (port_busy_t[p])
            );
        end
    endgenerate

    vlsu_timer u_gather  (.clock(clock), .rst_n(rst_n), .load(gat_load),
                          .count(vl_ext + GPORT_OFS), .busy(gather_t));
    vlsu_timer u_scatter (.clock(clock), .rst_n(rst_n), .load(sca_load),
                          .count(vl_ext + GPORT_OFS), .busy(scatter_t));
    vlsu_timer u_dest    (.clock(clock), .rst_n(rst_n), .load(dest_load),
                          .count(dest_cnt), .busy(dest_t));
    vlsu_timer u_src     (.clock(clock), .rst_n(rst_n), .load(src_load),
                          .count(vl_ext + SSTORE_SRC_OFS), .busy(src_t));
    vlsu_timer u_idx     (.clock(clock), .rst_n(rst_n), .load(idx_load),
                          .count(vl_ext + GIDX_OFS), .busy(idx_t));

    //////////////////////////////////////////////////////////////////////////
    // mode control
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dual_direction <= 1'b1;
        end else if (dual_direction_off) begin
            dual_direction <= 1'b0;
        end else if (dual_direction_on) begin
            dual_direction <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // sequencer: one element in flight on the request side, strictly in order
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= VLSU_IDLE;
        end else begin
            unique case (state)
                VLSU_IDLE: begin
                    if (go && vector_length_reg != '0) begin
                        state <= VLSU_REQ;
                    end
                end
                VLSU_REQ: begin
                    if (mem_accept && elem == total - 1'b1) begin
                        state <= cmd.op inside {VLSU_OP_SLOAD, VLSU_OP_GLOAD} ? VLSU_DONE : VLSU_IDLE;
                    end
                end
                VLSU_DONE: begin
                    if (rd_elem == total) begin
                        state <= VLSU_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd   <= '0;
            total <= '0;
            base  <= '0;
            step  <= UNIT_STRIDE;
        end else if (go) begin
            cmd   <= issue_cmd;
            total <= vector_length_reg;
            base  <= base_address_reg;
            step  <= (issue_cmd.stride_k == UNIT_STRIDE_K) ? UNIT_STRIDE : stride_reg;
        end
    end

    // next word may go out once the file shows its element; strided loads need no file read
    assign fetch_ok  = view_rd | (cmd.op == VLSU_OP_SLOAD);
    assign load_next = (state == VLSU_REQ) && fetch_ok && (off_elem != total)
                       && (!mem_req.req || mem_accept);

    // accepted count, offer pointer and address generation
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            elem     <= '0;
            off_elem <= '0;
            cur_addr <= '0;
        end else if (go) begin
            elem     <= '0;
            off_elem <= '0;
            cur_addr <= base_address_reg;
        end else begin
            if (state == VLSU_REQ && mem_req.req && mem_accept) begin
                elem <= elem + 1'b1;
            end
            if (load_next) begin
                off_elem <= off_elem + 1'b1;
                cur_addr <= cur_addr + step;
            end
        end
    end

    // read data returns in order; write each into the next target element
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_elem <= '0;
        end else if (go) begin
            rd_elem <= '0;
        end else if (mem_rvalid) begin
            rd_elem <= rd_elem + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vrf_we    <= 1'b0;
            vrf_wdata <= '0;
        end else begin
            vrf_we    <= mem_rvalid;
            vrf_wdata <= mem_rdata;
        end
    end

    // file index shows the next element to offer, except in a load write cycle;
    // a gather therefore loses one offer slot per returning word
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vrf_reg  <= '0;
            vrf_elem <= '0;
            view_rd  <= 1'b0;
        end else begin
            vrf_reg  <= go ? issue_cmd.vreg : cmd.vreg;
            if (go) begin
                vrf_elem <= '0;
                view_rd  <= 1'b1;
            end else if (mem_rvalid) begin
                vrf_elem <= rd_elem;
                view_rd  <= 1'b0;
            end else begin
                vrf_elem <= load_next ? off_elem + 1'b1 : off_elem;
                view_rd  <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // memory request: stable until accepted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_req  <= '0;
            mem_port <= PORT_B;
        end else begin
            mem_req.write <= cmd.op inside {VLSU_OP_SSTORE, VLSU_OP_SSCAT};
            if (load_next) begin
                mem_req.req <= 1'b1;
                if (cmd.op inside {VLSU_OP_GLOAD, VLSU_OP_SSCAT}) begin
                    mem_req.addr <= base + index_rdata[ADDR_W-1:0];
                end else begin
                    mem_req.addr <= cur_addr;
                end
                mem_req.wdata <= vrf_rdata;
            end else if (mem_accept) begin
                mem_req.req <= 1'b0;
            end
            if (go) begin
                mem_port <= is_load ? (use_b ? PORT_B : PORT_A) : PORT_C;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // status outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            issue_ack     <= 1'b0;
            port_busy     <= '0;
            gather_busy   <= 1'b0;
            scatter_busy  <= 1'b0;
            dest_pending  <= 1'b0;
            src_pending   <= 1'b0;
            index_pending <= 1'b0;
            chain_stall   <= 1'b0;
        end else begin
            issue_ack     <= go;
            port_busy     <= port_busy_t;
            gather_busy   <= gather_t;
            scatter_busy  <= scatter_t;
            dest_pending  <= dest_t;
            src_pending   <= src_t;
            index_pending <= idx_t;
            // memory refused a load word: chained consumers must wait
            chain_stall   <= (state == VLSU_REQ) && !mem_req.write && mem_req.req && !mem_accept;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_req_stable: assert property (@(posedge clock) disable iff (!rst_n)
        mem_req.req && !mem_accept |=> mem_req.addr == $past(mem_req.addr) || !mem_req.req)
        else $error("request address moved before acceptance");
    a_no_issue_busy: assert property (@(posedge clock) disable iff (!rst_n)
        go && !is_load |-> !port_busy_t[PORT_C])
        else $error("store issued on busy write port");
    a_base_hold: assert property (@(posedge clock) disable iff (!rst_n)
        base_reserved |-> !go)
        else $error("issue while base reserved");
    a_scalar_hold: assert property (@(posedge clock) disable iff (!rst_n)
        scalar_ref_early |-> !go)
        else $error("issue during scalar reference");
    a_mode_off: assert property (@(posedge clock) disable iff (!rst_n)
        dual_direction_off |=> !dual_direction)
        else $error("dual direction not switched off");
    a_unit_step: assert property (@(posedge clock) disable iff (!rst_n)
        go && issue_cmd.stride_k == UNIT_STRIDE_K |=> step == UNIT_STRIDE)
        else $error("unit stride not selected");
    a_ack_next: assert property (@(posedge clock) disable iff (!rst_n)
        go |=> issue_ack ##1 !issue_ack)
        else $error("issue acknowledge not one period");
    a_port_busy: assert property (@(posedge clock) disable iff (!rst_n)
        go && issue_cmd.op == VLSU_OP_SSTORE |=> port_busy_t[PORT_C])
        else $error("write port not busy after store issue");
    c_load: cover property (@(posedge clock) disable iff (!rst_n) go && issue_cmd.op == VLSU_OP_SLOAD);
    c_scatter: cover property (@(posedge clock) disable iff (!rst_n) go && issue_cmd.op == VLSU_OP_SSCAT);
    c_stall: cover property (@(posedge clock) disable iff (!rst_n) chain_stall);
endmodule
`default_nettype wire

/* File: bench/vlsu_mem_model.sv */
// memory model: interleaved banks, four-period bank busy, in-order reads
`default_nettype none
module vlsu_mem_model
    import vlsu_pkg::*;
(
    // clock and mode
    input  wire logic         clock,
    input  wire logic         slow,
    // port
    input  wire vlsu_mreq_s   mem_req,
    output logic              mem_accept,
    output logic              mem_rvalid,
    output logic [DATA_W-1:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    int bank_t [16];
    int now = 0;
    initial foreach (bank_t[i]) bank_t[i] = -8;
    initial mem_rvalid = 1'b0;
    initial mem_rdata = 64'h0;
    // successive addresses hit successive banks, each bank once per four periods
    assign mem_accept = mem_req.req && (now - bank_t[mem_req.addr[3:0]] >= 4) && !(slow && now[0]);
    always @(posedge clock) begin
        now <= now + 1;
        mem_rvalid <= mem_accept && !mem_req.write;
        if (mem_accept) bank_t[mem_req.addr[3:0]] <= now;
        // released data toggles so a stale value never matches
        mem_rdata <= (mem_accept && !mem_req.write) ? {40'h0, mem_req.addr} ^ 64'h5A00_0000_0000_0000 : ~mem_rdata;
    end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// testbench: issue sequences, address and data streams, timers, holds
`default_nettype none
module tb;
    import vlsu_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, resetn = 0, issue_req = 0, doff = 0, don = 0, slow = 0, issue_ack, acc, rv, we, dd;
    logic [3:0] hold = 0;
    logic [7:0] vres = 0;
    vlsu_cmd_s cmd = '0;
    logic [VLEN_W-1:0] vl = 0, elem;
    logic [ADDR_W-1:0] base = 24'h001000, stride = 0;
    logic [DATA_W-1:0] vrd, ird, wd, rd;
    logic [2:0] pb;
    logic [1:0] port;
    logic [VREG_W-1:0] vr;
    logic gb, sb, dp, sp, ip;
    vlsu_mreq_s mreq;
    logic [DATA_W-1:0] ga [$], gd [$];
    logic [1:0] gp [$];
    int err_count = 0, checks = 0;
    always #10 clock = ~clock;
    assign vrd = {57'h0, elem} ^ 64'hC300_0000_0000_0000;
    assign ird = {40'hFF_FFFF_FFFF, 24'hFFFFF0 + {17'h0, elem} * 24'h3};
    vlsu_top DUT (.clock(clock), .resetn(resetn), .issue_req(issue_req), .issue_cmd(cmd), .issue_ack(issue_ack),
        .dual_direction_off(doff), .dual_direction_on(don), .vector_length_reg(vl), .base_address_reg(base),
        .stride_reg(stride), .base_reserved(hold[0]), .stride_reserved(hold[1]), .scalar_ref_early(hold[2]),
        .vreg_reserved_operand(vres), .vreg_reserved_result(vres), .vrf_reg(vr), .vrf_elem(elem),
        .vrf_rdata(vrd), .index_rdata(ird), .vrf_we(we), .vrf_wdata(wd), .mem_req(mreq), .mem_port(port),
        .mem_accept(acc), .mem_rvalid(rv), .mem_rdata(rd), .port_busy(pb), .gather_busy(gb),
        .scatter_busy(sb), .dest_pending(dp), .src_pending(sp), .index_pending(ip), .chain_stall(),
        .dual_direction(dd));
    vlsu_mem_model MEM (.clock(clock), .slow(slow), .mem_req(mreq), .mem_accept(acc), .mem_rvalid(rv),
        .mem_rdata(rd));
    always @(posedge clock) begin
        if (mreq.req && acc) begin
            ga.push_back({40'h0, mreq.addr});
            gp.push_back(port);
        end
        if (mreq.req && acc && mreq.write) gd.push_back(mreq.wdata);
        if (we) gd.push_back(wd);
    end
    task automatic chk(logic [63:0] g, logic [63:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic run(vlsu_op_e op, logic [2:0] k, logic [6:0] n, logic [23:0] s, int po, int pd);
        int t, bp, dc;
        logic ld;
        logic [23:0] a;
        ld = op inside {VLSU_OP_SLOAD, VLSU_OP_GLOAD};
        ga.delete();
        gd.delete();
        gp.delete();
        bp = 0;
        dc = 0;
        @(posedge clock);
        cmd <= '{op, 3'h2, 3'h5, k};
        vl <= n;
        stride <= s;
        issue_req <= 1'b1;
        for (t = 0; t < 40 && issue_ack !== 1'b1; t++) @(negedge clock);
        chk(issue_ack, 1'b1);
        @(posedge clock) issue_req <= 1'b0;
        @(negedge clock);
        for (t = 0; t < 600; t++) begin
            bp += ld ? pb[1] : pb[2];
            dc += ld ? dp : sp;
            if (t > 2 && pb === 3'h0 && {gb, sb, dp, sp, ip} === 5'h0) break;
            @(negedge clock);
        end
        if (t >= 600) begin
            err_count++;
            print_verdict();
        end
        if (po >= 0) chk(bp, n + po);
        if (po >= 0) chk(dc, n + pd);
        chk(ga.size(), n);
        if (n > 0) chk(gp[0], ld ? PORT_B : PORT_C);
        a = base;
        for (int i = 0; i < ga.size() && i < n; i++) begin
            if (op inside {VLSU_OP_GLOAD, VLSU_OP_SSCAT}) a = base + 24'hFFFFF0 + 24'(i) * 24'h3;
            chk(ga[i], {40'h0, a});
            chk(gd[i], ld ? {40'h0, a} ^ 64'h5A00_0000_0000_0000 : 64'(i) ^ 64'hC300_0000_0000_0000);
            a = a + ((k == 3'h0) ? UNIT_STRIDE : s);
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        chk(dd, 1'b1);
        run(VLSU_OP_SLOAD, 3'h3, 7'h05, 24'h000003, 6, 17);
        run(VLSU_OP_SSTORE, 3'h0, 7'h04, 24'h000009, 7, 3);
        run(VLSU_OP_GLOAD, 3'h1, 7'h04, 24'h0, 10, 21);
        run(VLSU_OP_SSCAT, 3'h1, 7'h03, 24'h0, 10, 3);
        run(VLSU_OP_SSTORE, 3'h2, 7'h00, 24'h000001, -1, 0);
        slow <= 1'b1;
        // stride of minus 64 revisits one bank, so each word waits four periods
        run(VLSU_OP_SLOAD, 3'h2, 7'h06, 24'hFFFFC0, -1, 0);
        slow <= 1'b0;
        for (int h = 0; h < 4; h++) begin
            @(posedge clock);
            hold <= 4'(h < 3 ? 1 << h : 0);
            vres <= (h == 3) ? 8'h04 : 8'h00;
            cmd <= '{VLSU_OP_SLOAD, 3'h2, 3'h5, 3'h4};
            vl <= 7'h02;
            issue_req <= 1'b1;
            repeat (8) begin
                @(negedge clock);
                chk(issue_ack, 1'b0);
            end
            @(posedge clock);
            hold <= 4'h0;
            vres <= 8'h00;
            issue_req <= 1'b0;
        end
        run(VLSU_OP_SLOAD, 3'h4, 7'h02, 24'h000005, 6, 17);
        @(posedge clock) doff <= 1'b1;
        @(posedge clock) doff <= 1'b0;
        @(negedge clock) chk(dd, 1'b0);
        @(posedge clock) don <= 1'b1;
        @(posedge clock) don <= 1'b0;
        @(negedge clock) chk(dd, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
